// ===== hw/vcp_console.sv
// Operation
// - port 0 queues always; control and further port queues only with multiport
// - feature bit 0 offered: console column and row fields valid
// - feature bit 1 offered: port limit valid, control queues used
// - feature bit 2 offered: early character field valid
// - console columns and rows presented as two 16-bit little-endian fields
// - port limit presented as 32-bit little-endian field
// - early character write accepted any time, even unconfigured
// - only low byte of each early character write goes out
// - size fields updated before change notice; size is port 0's only (the code updates both on the same edge, for a resize on any port)
// - input data delivered through the port's receive slot, marked used
// - control message: 32-bit port, 16-bit event, 16-bit value, little-endian
// - device creates port with event 1, removes with event 2
// - never add an existing port or one at or above the limit
// - only remove a port previously added
// - device marks console ports with event 4; driver answers open with 1
// - resize is event 5 followed by 16-bit columns and rows
// - either side reports open state with event 6, 0 closed, 1 open
// - port name is event 7 followed by UTF-8 name without null
`timescale 1ns/1ps
module vcp_console (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // backend command port (device-originated control events)
  input  wire logic                  cmd_valid_i,
  input  wire vcp_pkg::vcp_ctl_msg_t cmd_i,
  output logic                       cmd_ready_o,
  output logic                       cmd_err_o,
  // backend input stream
  input  wire logic                  rx_valid_i,
  input  wire vcp_pkg::vcp_beat_t    rx_beat_i,
  output logic [vcp_pkg::NUM_PORTS-1:0] rx_full_o,
  // driver output stream and early characters
  output logic                       tx_valid_o,
  output vcp_pkg::vcp_beat_t         tx_beat_o,
  output logic                       char_valid_o,
  output logic [7:0]                 char_o,
  // driver-originated control events and config change notice
  output logic                       drv_msg_valid_o,
  output vcp_pkg::vcp_ctl_msg_t      drv_msg_o,
  output logic                       drv_ready_o,
  output logic                       cfg_change_o
);
  import vcp_pkg::*;

  // ==========================================================
  // state
  logic [31:0]           drv_feat_reg;
  logic [15:0]           cols_reg;
  logic [15:0]           rows_reg;
  logic [31:0]           cfg_gen_reg;
  logic [NUM_PORTS-1:0]  exists_reg;
  logic [NUM_PORTS-1:0]  open_reg;
  logic [NUM_PORTS-1:0]  console_reg;
  vcp_ctl_msg_t          crx_reg;
  logic                  crx_valid_reg;
  logic [31:0]           ctx_port_reg;
  logic [PORT_W-1:0]     rx_sel_reg;
  logic [7:0]            rx_data_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0]  rx_full_reg;
  logic                  wr_pend_reg;
  logic [ADDR_W-1:0]     wr_addr_reg;

  logic                  multiport;
  logic                  addr_ok;
  logic                  rd_go;
  logic                  wr_go;
  logic                  wr_now;
  logic [ADDR_W-1:0]     rd_addr;
  logic [31:0]           rd_data;
  logic                  cmd_take;
  logic                  cmd_ok;
  logic                  cmd_msg;
  logic [PORT_W-1:0]     cmd_port;
  logic                  cmd_in_range;
  logic                  crx_done;
  logic                  crx_valid_next;
  logic                  ctx_post;
  logic [PORT_W-1:0]     ctx_port;
  logic                  ctx_in_range;
  logic                  rx_pop;
  logic [PORT_W-1:0]     tx_port;
  logic                  tx_port_ok;

  // queues beyond port 0 only exist once multiport is negotiated
  assign multiport = drv_feat_reg[FEAT_MULTIPORT];

  // ==========================================================
  // AHB-Lite address phase: word transfers only, others ignored
  assign addr_ok = hsel_i & hready_i & htrans_i[HTRANS_NSEQ_BIT] & (hsize_i == HSIZE_WORD);
  assign rd_go   = addr_ok & ~hwrite_i;
  assign wr_go   = addr_ok & hwrite_i;
  assign rd_addr = haddr_i[ADDR_W-1:0];
  assign wr_now  = wr_pend_reg;

  // write address held into the data phase, where hwdata is valid
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= wr_go;
      wr_addr_reg <= rd_addr;
    end
  end

  // zero wait states, always OKAY; unmapped reads return zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
      hrdata_o    <= '0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (rd_go) begin
        hrdata_o <= rd_data;
      end
    end
  end

  // ==========================================================
  // read mux, sampled at the address phase
  always_comb begin
    rd_data = '0;
    case (rd_addr)
      OFS_FEATURES:   rd_data = FEAT_OFFERED;
      OFS_DRV_FEAT:   rd_data = drv_feat_reg;
      OFS_CONS_SIZE:  rd_data = {rows_reg, cols_reg};
      OFS_PORT_LIMIT: rd_data = PORT_LIMIT;
      OFS_CFG_GEN:    rd_data = cfg_gen_reg;
      OFS_QUEUES:     rd_data = multiport ? QUEUES_MULTI : QUEUES_BASE;
      OFS_PORT_STATE: rd_data = {20'h0_0000, console_reg, open_reg, exists_reg};
      OFS_CRX_PORT:   rd_data = crx_reg.port;
      OFS_CRX_MSG:    rd_data = {crx_reg.value, crx_reg.event_code};
      OFS_CRX_EXTRA:  rd_data = crx_reg.extra;
      OFS_CRX_STAT:   rd_data = {28'h000_0000, crx_reg.extra_len, crx_valid_reg};
      OFS_CTX_PORT:   rd_data = ctx_port_reg;
      OFS_RX_SEL:     rd_data = {30'h0000_0000, rx_sel_reg};
      OFS_RX_DATA:    rd_data = {23'h00_0000, rx_full_reg[rx_sel_reg], rx_data_reg[rx_sel_reg]};
      default:        rd_data = '0;
    endcase
  end

  // ==========================================================
  // negotiated features; only offered bits stick
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_feat_reg <= '0;
    end else if (wr_now && wr_addr_reg == OFS_DRV_FEAT) begin
      drv_feat_reg <= hwdata_i & FEAT_OFFERED;
    end
  end

  // early characters bypass every queue and every negotiation step
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      char_valid_o <= 1'b0;
      char_o       <= '0;
    end else begin
      char_valid_o <= wr_now && wr_addr_reg == OFS_EARLY_CHAR;
      if (wr_now && wr_addr_reg == OFS_EARLY_CHAR) begin
        char_o <= hwdata_i[7:0];
      end
    end
  end

  // ==========================================================
  // backend commands: checked, then posted to the control receive slot only with multiport
  assign cmd_port     = cmd_i.port[PORT_W-1:0];
  assign cmd_in_range = cmd_i.port < PORT_LIMIT;
  assign cmd_take     = cmd_valid_i & cmd_ready_o;

  always_comb begin
    cmd_ok  = 1'b0;
    cmd_msg = multiport;
    case (cmd_i.event_code)
      EV_PORT_ADD:    cmd_ok = multiport & cmd_in_range & ~exists_reg[cmd_port];
      EV_PORT_REMOVE: cmd_ok = multiport & cmd_in_range & exists_reg[cmd_port];
      EV_CONSOLE,
      EV_PORT_OPEN,
      EV_PORT_NAME:   cmd_ok = multiport & cmd_in_range & exists_reg[cmd_port];
      EV_RESIZE:      cmd_ok = 1'b1; // size update is legal even without multiport
      default:        cmd_ok = 1'b0;
    endcase
  end

  // the backend may only post while the control slot is empty
  assign crx_done       = wr_now && wr_addr_reg == OFS_CRX_DONE;
  assign crx_valid_next = (cmd_take & cmd_ok & cmd_msg) | (crx_valid_reg & ~crx_done);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_ready_o <= 1'b0;
      cmd_err_o   <= 1'b0;
    end else begin
      cmd_ready_o <= ~crx_valid_next;
      cmd_err_o   <= cmd_take & ~cmd_ok;
    end
  end

  // control receive slot; a new post wins over a same-cycle release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crx_valid_reg <= 1'b0;
      crx_reg       <= '0;
    end else begin
      crx_valid_reg <= crx_valid_next;
      if (cmd_take && cmd_ok && cmd_msg) begin
        crx_reg       <= cmd_i;
        crx_reg.value <= (cmd_i.event_code == EV_PORT_OPEN) ? cmd_i.value : 16'h0000;
        if (cmd_i.event_code == EV_RESIZE) begin
          crx_reg.extra     <= {cmd_i.extra[31:16], cmd_i.extra[15:0]};
          crx_reg.extra_len <= EXTRA_RESIZE;
        end else if (cmd_i.event_code != EV_PORT_NAME) begin
          crx_reg.extra     <= '0;
          crx_reg.extra_len <= '0;
        end
      end
    end
  end

  // ==========================================================
  // console size: fields change in the same edge the notice rises
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cols_reg     <= COLS_RESET;
      rows_reg     <= ROWS_RESET;
      cfg_gen_reg  <= '0;
      cfg_change_o <= 1'b0;
    end else begin
      cfg_change_o <= cmd_take && cmd_ok && cmd_i.event_code == EV_RESIZE;
      if (cmd_take && cmd_ok && cmd_i.event_code == EV_RESIZE) begin
        cols_reg    <= cmd_i.extra[15:0];
        rows_reg    <= cmd_i.extra[31:16];
        cfg_gen_reg <= cfg_gen_reg + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // driver control messages
  assign ctx_post     = wr_now && wr_addr_reg == OFS_CTX_MSG && multiport;
  assign ctx_port     = ctx_port_reg[PORT_W-1:0];
  assign ctx_in_range = ctx_port_reg < PORT_LIMIT;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctx_port_reg    <= '0;
      drv_msg_valid_o <= 1'b0;
      drv_msg_o       <= '0;
      drv_ready_o     <= 1'b0;
    end else begin
      if (wr_now && wr_addr_reg == OFS_CTX_PORT) begin
        ctx_port_reg <= hwdata_i;
      end
      drv_msg_valid_o <= ctx_post;
      if (ctx_post) begin
        drv_msg_o.port       <= ctx_port_reg;
        drv_msg_o.event_code <= hwdata_i[15:0];
        drv_msg_o.value      <= hwdata_i[31:16];
        drv_msg_o.extra      <= '0;
        drv_msg_o.extra_len  <= '0;
        if (hwdata_i[15:0] == EV_DRV_READY) begin
          drv_ready_o <= hwdata_i[16];
        end
      end
    end
  end

  // ==========================================================
  // port presence, console marks and open state from both sides
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exists_reg  <= '0;
      console_reg <= '0;
      open_reg    <= '0;
    end else begin
      if (ctx_post && ctx_in_range && hwdata_i[15:0] == EV_PORT_OPEN) begin
        open_reg[ctx_port] <= hwdata_i[16];
      end
      if (cmd_take && cmd_ok) begin
        case (cmd_i.event_code)
          EV_PORT_ADD: begin
            exists_reg[cmd_port] <= 1'b1;
          end
          EV_PORT_REMOVE: begin
            exists_reg[cmd_port]  <= 1'b0;
            console_reg[cmd_port] <= 1'b0;
            open_reg[cmd_port]    <= 1'b0;
          end
          EV_CONSOLE: begin
            console_reg[cmd_port] <= 1'b1;
          end
          EV_PORT_OPEN: begin
            open_reg[cmd_port] <= cmd_i.value[0];
          end
          default: begin
            open_reg[cmd_port] <= open_reg[cmd_port];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // receive slots: one byte per port, freed when the driver reads it
  assign rx_pop = rd_go && rd_addr == OFS_RX_DATA;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sel_reg <= '0;
    end else if (wr_now && wr_addr_reg == OFS_RX_SEL) begin
      rx_sel_reg <= hwdata_i[PORT_W-1:0];
    end
  end

  // a byte for a port without a queue or with a full slot is dropped; a same-cycle read still frees the slot
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_full_reg <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        rx_data_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (rx_valid_i && rx_beat_i.port == PORT_W'(i) && (i == 0 || multiport) && !rx_full_reg[i]) begin
          rx_data_reg[i] <= rx_beat_i.data;
          rx_full_reg[i] <= 1'b1;
        end else if (rx_pop && rx_sel_reg == PORT_W'(i)) begin
          rx_full_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_full_o <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        rx_full_o[i] <= (rx_full_reg[i] & ~(rx_pop && rx_sel_reg == PORT_W'(i)))
                      | (rx_valid_i && rx_beat_i.port == PORT_W'(i) && (i == 0 || multiport) && !rx_full_reg[i]);
      end
    end
  end

  // ==========================================================
  // transmit: port 0 always, other ports only with multiport
  assign tx_port    = hwdata_i[8 +: PORT_W];
  assign tx_port_ok = (tx_port == '0) | multiport;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_valid_o <= 1'b0;
      tx_beat_o  <= '0;
    end else begin
      tx_valid_o <= wr_now && wr_addr_reg == OFS_TX_DATA && tx_port_ok;
      if (wr_now && wr_addr_reg == OFS_TX_DATA && tx_port_ok) begin
        tx_beat_o.port <= tx_port;
        tx_beat_o.data <= hwdata_i[7:0];
      end
    end
  end

endmodule

// ===== hw/vcp_pkg.sv
package vcp_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PORT_W    = 2;
  localparam int unsigned ADDR_W    = 8;

  // ==========================================================
  // feature bits offered by the device
  localparam int unsigned FEAT_SIZE      = 0;
  localparam int unsigned FEAT_MULTIPORT = 1;
  localparam int unsigned FEAT_EARLY_WR  = 2;
  localparam logic [31:0] FEAT_OFFERED   = 32'h0000_0007;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FEATURES   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DRV_FEAT   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONS_SIZE  = 8'h08;  // console_columns [15:0], console_rows [31:16]
  localparam logic [ADDR_W-1:0] OFS_PORT_LIMIT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EARLY_CHAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CFG_GEN    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_QUEUES     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PORT_STATE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CRX_PORT   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CRX_MSG    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CRX_EXTRA  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CRX_STAT   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_CRX_DONE   = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CTX_PORT   = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_CTX_MSG    = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_RX_SEL     = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA    = 8'h44;

  // ==========================================================
  // reset values and queue counts
  localparam logic [15:0] COLS_RESET   = 16'h0050;
  localparam logic [15:0] ROWS_RESET   = 16'h0018;
  localparam logic [31:0] QUEUES_BASE  = 32'h0000_0002;
  localparam logic [31:0] QUEUES_MULTI = 32'h0000_0002 * (NUM_PORTS + 1);
  localparam logic [31:0] PORT_LIMIT   = 32'h0000_0004;
  localparam logic [2:0]  EXTRA_RESIZE = 3'h4;
  localparam int unsigned RX_FULL_BIT  = 8;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned HTRANS_NSEQ_BIT = 1;

  // ==========================================================
  // control events
  typedef enum logic [15:0] {
    EV_DRV_READY   = 16'h0000,
    EV_PORT_ADD    = 16'h0001,
    EV_PORT_REMOVE = 16'h0002,
    EV_PORT_READY  = 16'h0003,
    EV_CONSOLE     = 16'h0004,
    EV_RESIZE      = 16'h0005,
    EV_PORT_OPEN   = 16'h0006,
    EV_PORT_NAME   = 16'h0007
  } vcp_event_t;

  // control message plus optional trailing bytes (resize counts or name)
  typedef struct packed {
    logic [31:0] port;
    logic [15:0] event_code;
    logic [15:0] value;
    logic [31:0] extra;
    logic [2:0]  extra_len;
  } vcp_ctl_msg_t;

  // byte stream beat for one port
  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [7:0]        data;
  } vcp_beat_t;

endpackage

// ===== verif/vcp_console_sva.sv
`timescale 1ns/1ps
module vcp_console_sva (
  input wire logic                          clk_i,
  input wire logic                          rst_b_i,
  input wire logic                          hsel_i,
  input wire logic [31:0]                   haddr_i,
  input wire logic [1:0]                    htrans_i,
  input wire logic                          hwrite_i,
  input wire logic [2:0]                    hsize_i,
  input wire logic [31:0]                   hwdata_i,
  input wire logic                          hready_i,
  input wire logic                          cmd_valid_i,
  input wire vcp_pkg::vcp_ctl_msg_t         cmd_i,
  input wire logic                          cmd_ready_o,
  input wire logic                          cmd_err_o,
  input wire logic                          rx_valid_i,
  input wire vcp_pkg::vcp_beat_t            rx_beat_i,
  input wire logic [vcp_pkg::NUM_PORTS-1:0] rx_full_o,
  input wire logic                          char_valid_o,
  input wire logic [7:0]                    char_o,
  input wire logic                          cfg_change_o
);
  import vcp_pkg::*;
  // ==========================================================
  // helpers: a command is taken only while the slot is free
  logic taken;
  assign taken = cmd_valid_i && cmd_ready_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // address phase then data phase of a word write to the early char field
  sequence s_early_wr;
    hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == HSIZE_WORD
      && haddr_i[7:0] == OFS_EARLY_CHAR ##1 hready_i;
  endsequence
  property p_char;
    s_early_wr |=> char_valid_o && char_o == $past(hwdata_i[7:0]);
  endproperty
  a_char: assert property (p_char) else $error("early char not forwarded");
  property p_err_cause;
    cmd_err_o |-> $past(taken);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("refusal without command");
  property p_add_limit;
    taken && cmd_i.event_code == EV_PORT_ADD && cmd_i.port >= PORT_LIMIT |=> cmd_err_o;
  endproperty
  a_add_limit: assert property (p_add_limit) else $error("add above limit accepted");
  property p_rm_limit;
    taken && cmd_i.event_code == EV_PORT_REMOVE && cmd_i.port >= PORT_LIMIT |=> cmd_err_o;
  endproperty
  a_rm_limit: assert property (p_rm_limit) else $error("remove of absent port accepted");
  property p_slot_fill;
    $fell(cmd_ready_o) |-> $past(taken);
  endproperty
  a_slot_fill: assert property (p_slot_fill) else $error("slot filled without command");
  property p_resize;
    taken && cmd_i.event_code == EV_RESIZE && cmd_i.port == 32'h0000_0000 |=> cfg_change_o;
  endproperty
  a_resize: assert property (p_resize) else $error("resize without change notice");
  property p_notice_cause;
    cfg_change_o |-> $past(taken && cmd_i.event_code == EV_RESIZE);
  endproperty
  a_notice_cause: assert property (p_notice_cause) else $error("spurious change notice");
  property p_rx_fill;
    rx_valid_i && rx_beat_i.port == 2'h0 && !rx_full_o[0] |=> rx_full_o[0];
  endproperty
  a_rx_fill: assert property (p_rx_fill) else $error("port 0 byte not held");
endmodule
bind vcp_console vcp_console_sva u_sva (.clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hsize_i, .hwdata_i, .hready_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .cmd_err_o, .rx_valid_i,
  .rx_beat_i, .rx_full_o, .char_valid_o, .char_o, .cfg_change_o);

// ===== verif/vcp_drv_model.sv
`timescale 1ns/1ps
module vcp_drv_model (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  import vcp_pkg::*;
  // ==========================================================
  // idle bus at time zero
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0000_0000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = HSIZE_WORD;
    hwdata_o = 32'h0000_0000;
  end
  // one word transfer; released write data is inverted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h00_0000, a};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    hsize_o  <= HSIZE_WORD;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= wr ? d : ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hwdata_o <= ~hwdata_o;
  endtask
endmodule

// ===== verif/vcp_console_tb.sv
`timescale 1ns/1ps
module vcp_console_tb;
  import vcp_pkg::*;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_b_i, hsel, hwrite, hready, hresp, cmd_valid, cmd_ready, cmd_err, rx_valid;
  logic tx_valid, char_valid, drv_valid, drv_ready, cfg_change;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] rx_full;
  logic [7:0] char_d, char_seen;
  vcp_ctl_msg_t cmd, drv_msg, drv_seen;
  vcp_beat_t rx_beat, tx_beat, tx_seen;
  int unsigned checks = 0, fails = 0, cyc = 0, errs = 0, cfgs = 0;
  always #12.5 clk_i = ~clk_i;
  vcp_console uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready),
    .cmd_err_o(cmd_err), .rx_valid_i(rx_valid), .rx_beat_i(rx_beat), .rx_full_o(rx_full),
    .tx_valid_o(tx_valid), .tx_beat_o(tx_beat), .char_valid_o(char_valid), .char_o(char_d),
    .drv_msg_valid_o(drv_valid), .drv_msg_o(drv_msg), .drv_ready_o(drv_ready), .cfg_change_o(cfg_change));
  vcp_drv_model drv (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  // ==========================================================
  // closing report
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // pulse monitor and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cmd_err === 1'b1) errs <= errs + 1;
    if (cfg_change === 1'b1) cfgs <= cfgs + 1;
    if (char_valid === 1'b1) char_seen <= char_d;
    if (tx_valid === 1'b1) tx_seen <= tx_beat;
    if (drv_valid === 1'b1) drv_seen <= drv_msg;
    if (cyc == 5000) begin
      fails = fails + 1;
      finish_test();
    end
  end
  // ==========================================================
  // access tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drv.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    drv.xfer(1'b0, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  // backend command held until the slot is free, then two edges for the answer
  task automatic send(input logic [31:0] p, input logic [15:0] ev, input logic [15:0] v,
                      input logic [31:0] x, input logic [2:0] l);
    @(posedge clk_i);
    cmd       <= {p, ev, v, x, l};
    cmd_valid <= 1'b1;
    do @(posedge clk_i); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // device message: post, read back the control slot, free it
  task automatic devmsg(input logic [31:0] p, input logic [15:0] ev, input logic [15:0] v,
                        input logic [31:0] x, input logic [2:0] l);
    send(p, ev, v, x, l);
    rdc("crx port", OFS_CRX_PORT, p);
    rdc("crx msg", OFS_CRX_MSG, {v, ev});
    rdc("crx stat", OFS_CRX_STAT, {28'h000_0000, l, 1'b1});
    if (l != 3'h0) rdc("crx extra", OFS_CRX_EXTRA, x);
    wr(OFS_CRX_DONE, 32'h0000_0000);
  endtask
  // driver message on port 1 and what reaches the backend
  task automatic drvmsg(input logic [15:0] ev, input logic [15:0] v);
    wr(OFS_CTX_MSG, {v, ev});
    repeat (2) @(posedge clk_i);
    chk("drv msg", {v, ev}, {drv_seen.value, drv_seen.event_code});
    chk("drv port", 32'h0000_0001, drv_seen.port);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_b_i = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    rx_valid = 1'b0;
    rx_beat = '0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdc("features", OFS_FEATURES, 32'h0000_0007);
    rdc("size", OFS_CONS_SIZE, 32'h0018_0050);
    rdc("limit", OFS_PORT_LIMIT, 32'h0000_0004);
    rdc("queues", OFS_QUEUES, 32'h0000_0002);
    rdc("unmapped", 8'h80, 32'h0000_0000);
    wr(OFS_EARLY_CHAR, 32'h1234_56A5);
    repeat (2) @(posedge clk_i);
    chk("early char", 32'h0000_00A5, {24'h00_0000, char_seen});
    send(32'h0000_0000, EV_RESIZE, 16'h0000, 32'h0030_0064, 3'h4);
    rdc("size new", OFS_CONS_SIZE, 32'h0030_0064);
    rdc("gen", OFS_CFG_GEN, 32'h0000_0001);
    rdc("no ctl msg", OFS_CRX_STAT, 32'h0000_0000);
    send(32'h0000_0001, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 3'h0);
    wr(OFS_DRV_FEAT, 32'h0000_0007);
    rdc("queues multi", OFS_QUEUES, 32'h0000_000A);
    devmsg(32'h0000_0001, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 3'h0);
    devmsg(32'h0000_0001, EV_CONSOLE, 16'h0000, 32'h0000_0000, 3'h0);
    devmsg(32'h0000_0001, EV_PORT_OPEN, 16'h0001, 32'h0000_0000, 3'h0);
    devmsg(32'h0000_0001, EV_PORT_NAME, 16'h0000, 32'h0000_6261, 3'h2);
    devmsg(32'h0000_0000, EV_RESIZE, 16'h0000, 32'h0019_0078, 3'h4);
    rdc("size multi", OFS_CONS_SIZE, 32'h0019_0078);
    chk("notices", 32'h0000_0002, 32'(cfgs));
    drv.xfer(1'b0, OFS_PORT_STATE, 32'h0000_0000, q);
    chk("port state", 32'h0000_0222, q & 32'h0000_0FFF);
    send(32'h0000_0001, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 3'h0);
    send(32'h0000_0004, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 3'h0);
    send(32'h0000_0002, EV_PORT_REMOVE, 16'h0000, 32'h0000_0000, 3'h0);
    send(32'h0000_0006, EV_PORT_REMOVE, 16'h0000, 32'h0000_0000, 3'h0);
    chk("refusals", 32'h0000_0005, 32'(errs));
    wr(OFS_CTX_PORT, 32'h0000_0001);
    drvmsg(EV_DRV_READY, 16'h0001);
    chk("drv ready", 32'h0000_0001, {31'h0000_0000, drv_ready});
    drvmsg(EV_PORT_READY, 16'h0001);
    drvmsg(EV_PORT_OPEN, 16'h0001);
    drvmsg(EV_DRV_READY, 16'h0000);
    chk("drv not ready", 32'h0000_0000, {31'h0000_0000, drv_ready});
    @(posedge clk_i);
    rx_valid <= 1'b1;
    rx_beat  <= {2'h1, 8'h41};
    @(posedge clk_i);
    rx_beat  <= {2'h0, 8'h42};
    @(posedge clk_i);
    rx_valid <= 1'b0;
    @(posedge clk_i);
    chk("rx full", 32'h0000_0003, {28'h000_0000, rx_full});
    wr(OFS_RX_SEL, 32'h0000_0001);
    rdc("rx data", OFS_RX_DATA, 32'h0000_0141);
    repeat (2) @(posedge clk_i);
    chk("rx popped", 32'h0000_0001, {28'h000_0000, rx_full});
    wr(OFS_TX_DATA, 32'h0000_015A);
    repeat (2) @(posedge clk_i);
    chk("tx beat", 32'h0000_015A, {22'h00_0000, tx_seen});
    devmsg(32'h0000_0001, EV_PORT_REMOVE, 16'h0000, 32'h0000_0000, 3'h0);
    drv.xfer(1'b0, OFS_PORT_STATE, 32'h0000_0000, q);
    chk("port gone", 32'h0000_0000, q & 32'h0000_0FFF);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    finish_test();
  end
endmodule
